// ===== hw/apc_pkg.sv
// constants, types and register map of the power mode controller
package apc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 100;
	localparam int READY_NS     = 2000;
	localparam int READY_CYC_I  = (READY_NS * CLK_MHZ + 999) / 1000;
	localparam logic [15:0] READY_CYC = 16'(READY_CYC_I);

	// ------------------------------------------------------------
	// serial frame
	// ------------------------------------------------------------
	localparam int FRAME_BITS   = 8;
	localparam int CONV_BITS    = 12;
	localparam int PWR_FIELD_LSB = 0;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_COUNT  = 12'h008;

	localparam int ST_MODE_LSB  = 0;
	localparam int ST_HW_DOWN   = 2;
	localparam int ST_CONV      = 3;
	localparam int ST_READY     = 4;
	localparam int ST_FIELD_LSB = 5;
	localparam int ST_AWAKE     = 7;
	localparam int ST_ABORT     = 8;

	localparam logic [31:0] CTRL_RESET  = {16'h0000, READY_CYC};
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_DEEP   = 2'b00,
		PM_QUICK  = 2'b01,
		PM_LOWP   = 2'b10,
		PM_NORMAL = 2'b11
	} apc_mode_t;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_SHIFT = 2'b01,
		PH_WAIT  = 2'b10,
		PH_CONV  = 2'b11
	} apc_phase_t;

	typedef struct packed {
		apc_mode_t mode;
		logic      hw_down;
		logic      comp_on;
		logic      comp_full;
		logic      ref_on;
		logic      ready;
		logic      converting;
	} apc_pwr_t;

	typedef struct packed {
		logic awake;
		logic conv_start_t;
		logic conv_end_t;
		logic done_t;
	} apc_link_t;

endpackage

// ===== hw/apc_frame_rx.sv
// serial-clock side: start bit, control byte capture and conversion framing
`timescale 1ns/1ps
module apc_frame_rx
	import apc_pkg::*;
#(
	parameter int CONV_LEN = CONV_BITS
) (
	input  wire logic      sclk_i,
	input  wire logic      link_rst_n_i,
	input  wire logic      cs_n_i,
	input  wire logic      din_i,
	output apc_link_t      link_o,
	output logic [1:0]     field_o
);

	initial begin
		if (CONV_LEN < 1 || CONV_LEN > 15) begin
			$error("CONV_LEN out of range");
		end
	end

	localparam logic [3:0] LAST_BIT  = 4'(FRAME_BITS - 1);
	localparam logic [3:0] LAST_CONV = 4'(CONV_LEN - 1);

	apc_phase_t phase;
	logic [3:0] cnt;
	logic       prev_bit;
	logic       awake;
	logic       done_t;
	logic       conv_end_t;
	logic       conv_start_t;

	// each flag has one process; the struct only gathers them
	assign link_o = {awake, conv_start_t, conv_end_t, done_t};

	// ------------------------------------------------------------
	// rising edge: framing
	// ------------------------------------------------------------
	always_ff @(posedge sclk_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			phase         <= PH_IDLE;
			cnt           <= 4'h0;
			prev_bit      <= 1'b0;
			field_o       <= 2'h0;
			awake         <= 1'b0;
			done_t        <= 1'b0;
			conv_end_t    <= 1'b0;
		end else begin
			unique case (phase)
				PH_IDLE: begin
					// first one with select low is the start bit
					if (!cs_n_i && din_i) begin
						phase        <= PH_SHIFT;
						awake        <= 1'b1;
						cnt          <= 4'h1;
					end
				end
				PH_SHIFT: begin
					if (cs_n_i) begin
						phase        <= PH_IDLE;
						awake        <= 1'b0;
					end else begin
						prev_bit <= din_i;
						cnt      <= cnt + 4'h1;
						if (cnt == LAST_BIT) begin
							field_o       <= {prev_bit, din_i};
							done_t        <= ~done_t;
							phase         <= PH_WAIT;
						end
					end
				end
				PH_WAIT: begin
					// falling edge in between has started the conversion
					phase <= PH_CONV;
					cnt   <= 4'h0;
				end
				PH_CONV: begin
					// serial input ignored until the conversion ends
					cnt <= cnt + 4'h1;
					if (cnt == LAST_CONV) begin
						phase             <= PH_IDLE;
						awake             <= 1'b0;
						conv_end_t        <= ~conv_end_t;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// falling edge: conversion start
	// ------------------------------------------------------------
	always_ff @(negedge sclk_i or negedge link_rst_n_i) begin
		if (!link_rst_n_i) begin
			conv_start_t <= 1'b0;
		end else if (phase == PH_WAIT) begin
			conv_start_t <= ~conv_start_t;
		end
	end

endmodule

// ===== hw/apc_power_ctrl.sv
// power mode controller top: pin sync, power state, wake timing, apb registers
//
// Functional notes
// - power field is control byte bits 1:0
// - 00 deep, 01 quick, 10 idle, 11 normal
// - software state applied only after conversion
// - shutdown low aborts and powers down now
// - serial input stays live in low power
// - first one on data in wakes fully
// - after conversion enter latest selected state
// - reset or deep/shutdown exit: full, ready later
// - quick and idle convert without wake delay
// - sections powered per state, full while converting
// - conversion starts on falling edge after bit 8
// - only shutdown ends a started conversion
`timescale 1ns/1ps
module apc_power_ctrl
	import apc_pkg::*;
#(
	parameter int CONV_LEN = CONV_BITS
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        din_i,
	input  wire logic        hw_shutdown_n_i,
	output apc_pwr_t         pwr_o
);

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	initial begin
		if (CONV_LEN < 1 || CONV_LEN > 15) begin
			$error("CONV_LEN out of range");
		end
	end

	// ------------------------------------------------------------
	// section decode
	// ------------------------------------------------------------
	// returns {comp_on, comp_full, ref_on}
	function automatic logic [2:0] apc_sections(input apc_mode_t m, input logic conv,
		input logic hw);
		logic [2:0] s;
		s = 3'h0;
		if (hw) begin
			s = 3'h0;
		end else if (conv) begin
			s = 3'h7;
		end else begin
			unique case (m)
				PM_DEEP:   s = 3'h0;
				PM_QUICK:  s = 3'h5;
				PM_LOWP:   s = 3'h5;
				PM_NORMAL: s = 3'h7;
			endcase
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// link side
	// ------------------------------------------------------------
	logic       link_rst_n;
	apc_link_t  link;
	logic [1:0] link_field;

	// shutdown resets the link logic at once, without any clock edge
	assign link_rst_n = rst_n_i & hw_shutdown_n_i;

	apc_frame_rx #(
		.CONV_LEN (CONV_LEN)
	) u_frame (
		.sclk_i       (sclk_i),
		.link_rst_n_i (link_rst_n),
		.cs_n_i       (cs_n_i),
		.din_i        (din_i),
		.link_o       (link),
		.field_o      (link_field)
	);

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	localparam int SY_HW_SHUTDOWN_N  = 0;
	localparam int SY_AWAKE = 1;
	localparam int SY_CONV  = 2;
	localparam int SY_DONE  = 3;
	localparam int SY_W     = 4;
	localparam logic [SY_W-1:0] SY_RESET = 4'h1;

	logic [SY_W-1:0] sy_in;
	logic [SY_W-1:0] sy_s1;
	logic [SY_W-1:0] sy_s2;
	logic [SY_W-1:0] sy_s3;
	logic [SY_W-1:0] sy_flt;
	logic [SY_W-1:0] sy_prev;

	// levels and toggles only; the field word rides on the done toggle
	assign sy_in[SY_HW_SHUTDOWN_N]  = hw_shutdown_n_i;
	assign sy_in[SY_AWAKE] = link.awake;
	assign sy_in[SY_CONV]  = link.conv_start_t ^ link.conv_end_t;
	assign sy_in[SY_DONE]  = link.done_t;

	genvar gi;
	generate
		for (gi = 0; gi < SY_W; gi++) begin : g_sync
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					sy_s1[gi]   <= SY_RESET[gi];
					sy_s2[gi]   <= SY_RESET[gi];
					sy_s3[gi]   <= SY_RESET[gi];
					sy_flt[gi]  <= SY_RESET[gi];
					sy_prev[gi] <= SY_RESET[gi];
				end else begin
					sy_s1[gi]   <= sy_in[gi];
					sy_s2[gi]   <= sy_s1[gi];
					sy_s3[gi]   <= sy_s2[gi];
					sy_prev[gi] <= sy_flt[gi];
					if (sy_s2[gi] == sy_s3[gi]) begin
						sy_flt[gi] <= sy_s3[gi];
					end
				end
			end
		end
	endgenerate

	logic hw_shutdown_n_low;
	logic hw_shutdown_n_fall;
	logic hw_shutdown_n_rise;
	logic awake_rise;
	logic conv_fall;
	logic done_evt;
	logic converting;

	assign hw_shutdown_n_low   = ~sy_flt[SY_HW_SHUTDOWN_N];
	assign hw_shutdown_n_fall  = sy_prev[SY_HW_SHUTDOWN_N] & ~sy_flt[SY_HW_SHUTDOWN_N];
	assign hw_shutdown_n_rise  = ~sy_prev[SY_HW_SHUTDOWN_N] & sy_flt[SY_HW_SHUTDOWN_N];
	assign awake_rise = ~sy_prev[SY_AWAKE] & sy_flt[SY_AWAKE];
	assign conv_fall  = sy_prev[SY_CONV] & ~sy_flt[SY_CONV];
	assign done_evt   = sy_prev[SY_DONE] ^ sy_flt[SY_DONE];
	assign converting = sy_flt[SY_CONV];

	// ------------------------------------------------------------
	// captured power field
	// ------------------------------------------------------------
	apc_mode_t field_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			field_q <= PM_NORMAL;
		end else if (done_evt && !hw_shutdown_n_low) begin
			// shutdown clears the link toggles; that edge is no control byte
			// link field stays stable for a whole byte after its toggle
			field_q <= apc_mode_t'(link_field);
		end
	end

	// ------------------------------------------------------------
	// power state
	// ------------------------------------------------------------
	apc_mode_t mode;
	logic      hw_down;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= PM_NORMAL;
		end else if (hw_shutdown_n_low) begin
			mode <= PM_NORMAL;
		end else if (awake_rise) begin
			mode <= PM_NORMAL;
		end else if (conv_fall) begin
			mode <= field_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hw_down <= 1'b0;
		end else begin
			hw_down <= hw_shutdown_n_low;
		end
	end

	// ------------------------------------------------------------
	// wake timing
	// ------------------------------------------------------------
	logic [31:0] ctrl;
	logic [15:0] wake_cnt;
	logic        ready;
	logic        wake_evt;

	assign wake_evt = hw_shutdown_n_rise | (awake_rise & (mode == PM_DEEP));

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_cnt <= READY_CYC;
			ready    <= 1'b0;
		end else if (hw_shutdown_n_low) begin
			wake_cnt <= ctrl[15:0];
			ready    <= 1'b0;
		end else if (wake_evt) begin
			wake_cnt <= ctrl[15:0];
			ready    <= 1'b0;
		end else if (mode == PM_DEEP && !sy_flt[SY_AWAKE]) begin
			ready <= 1'b0;
		end else if (wake_cnt != 16'h0000) begin
			wake_cnt <= wake_cnt - 16'h0001;
		end else begin
			// quick and idle never leave ready
			ready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// power outputs
	// ------------------------------------------------------------
	apc_pwr_t   next_pwr;
	logic [2:0] sect;

	always_comb begin
		sect                = apc_sections(mode, converting, hw_shutdown_n_low);
		next_pwr.mode       = mode;
		next_pwr.hw_down    = hw_shutdown_n_low;
		next_pwr.comp_on    = sect[2];
		next_pwr.comp_full  = sect[1];
		next_pwr.ref_on     = sect[0];
		next_pwr.ready      = ready & ~hw_shutdown_n_low;
		next_pwr.converting = converting & ~hw_shutdown_n_low;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_o <= '0;
		end else begin
			pwr_o <= next_pwr;
		end
	end

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	// one hit bit per register: {count, status, ctrl}
	function automatic logic [2:0] apc_reg_hit(input logic [11:0] a);
		logic [2:0] h;
		h    = 3'h0;
		h[0] = (a == REG_CTRL);
		h[1] = (a == REG_STATUS);
		h[2] = (a == REG_COUNT);
		return h;
	endfunction

	// ------------------------------------------------------------
	// conversion count and abort flag
	// ------------------------------------------------------------
	logic [15:0] conv_count;
	logic        aborted;
	logic        abort_evt;
	logic        wr_en;
	logic        rd_setup;
	logic        mapped;
	logic [2:0]  hit;

	// shutdown and the cleared conversion toggle may arrive in either order
	assign abort_evt = (hw_shutdown_n_fall & converting) | (conv_fall & hw_shutdown_n_low);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_count <= COUNT_RESET;
		end else if (conv_fall && !hw_shutdown_n_low) begin
			conv_count <= conv_count + 16'h0001;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aborted <= 1'b0;
		end else if (abort_evt) begin
			// an abort in the clearing cycle is kept
			aborted <= 1'b1;
		end else if (wr_en && hit[1] && pwdata_i[ST_ABORT]) begin
			aborted <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [31:0] status;

	always_comb begin
		status                               = 32'h0000_0000;
		status[ST_MODE_LSB +: 2]             = mode;
		status[ST_HW_DOWN]                   = hw_down;
		status[ST_CONV]                      = converting;
		status[ST_READY]                     = ready & ~hw_down;
		status[ST_FIELD_LSB +: 2]            = field_q;
		status[ST_AWAKE]                     = sy_flt[SY_AWAKE];
		status[ST_ABORT]                     = aborted;
	end

	assign hit       = apc_reg_hit(paddr_i);
	assign mapped    = |hit;
	assign wr_en     = psel_i & penable_i & pwrite_i & mapped;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= CTRL_RESET;
		end else if (wr_en && hit[0]) begin
			ctrl <= {16'h0000, pwdata_i[15:0]};
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (paddr_i)
				REG_CTRL:   prdata_o <= ctrl;
				REG_STATUS: prdata_o <= status;
				REG_COUNT:  prdata_o <= {16'h0000, conv_count};
				default:    prdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ===== bench/apc_host_model.sv
// serial host model: control byte then conversion clocks, clock still between frames
`timescale 1ns/1ps
module apc_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o  = 1'b1;
	end

	// ------------------------------------------------------------
	// one frame of 24 clocks, msb first
	// ------------------------------------------------------------
	task automatic frame(input logic [7:0] cb, input bit slow);
		realtime h;
		h = slow ? 250.0 : 62.5;
		cs_n_o = 1'b0;
		for (int i = 0; i < 24; i++) begin
			din_o = (i < 8) ? cb[7 - i] : 1'b0;
			#(h);
			sclk_o = 1'b1;
			#(h);
			sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		din_o  = ~din_o;
	endtask
endmodule

// ===== bench/apc_power_ctrl_checker.sv
// port assertions of the power mode controller
`timescale 1ns/1ps
module apc_power_ctrl_checker
	import apc_pkg::*;
(
	input wire logic     clock_i,
	input wire logic     rst_n_i,
	input wire logic     hw_shutdown_n_i,
	input wire apc_pwr_t pwr_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// sections and shutdown
	// ------------------------------------------------------------
	sequence s_shut_held;
		!hw_shutdown_n_i [*8];
	endsequence
	sequence s_awake;
		pwr_o.mode == PM_NORMAL && !pwr_o.hw_down;
	endsequence
	property p_conv_full;
		pwr_o.converting |-> pwr_o.comp_on && pwr_o.comp_full && pwr_o.ref_on;
	endproperty
	a_conv_full: assert property (p_conv_full)
		else $error("section off while converting");
	property p_deep_off;
		pwr_o.mode == PM_DEEP && !pwr_o.converting |-> !pwr_o.comp_on && !pwr_o.ref_on;
	endproperty
	a_deep_off: assert property (p_deep_off)
		else $error("deep sleep left a section on");
	property p_sleep_red;
		(pwr_o.mode == PM_QUICK || pwr_o.mode == PM_LOWP) && !pwr_o.converting
			&& !pwr_o.hw_down
			|-> pwr_o.comp_on && !pwr_o.comp_full && pwr_o.ref_on;
	endproperty
	a_sleep_red: assert property (p_sleep_red)
		else $error("sleep sections wrong");
	property p_normal_full;
		s_awake |-> pwr_o.comp_on && pwr_o.comp_full && pwr_o.ref_on;
	endproperty
	a_normal_full: assert property (p_normal_full)
		else $error("normal sections wrong");
	property p_shut_abort;
		s_shut_held |-> pwr_o.hw_down && !pwr_o.converting && !pwr_o.comp_on;
	endproperty
	a_shut_abort: assert property (p_shut_abort)
		else $error("shutdown did not stop");
	property p_shut_seen;
		$fell(hw_shutdown_n_i) |-> ##[1:8] pwr_o.hw_down;
	endproperty
	a_shut_seen: assert property (p_shut_seen)
		else $error("shutdown not seen");
	property p_wake_hw;
		$rose(hw_shutdown_n_i) |-> ##[1:8] s_awake;
	endproperty
	a_wake_hw: assert property (p_wake_hw)
		else $error("no full power after shutdown");
	property p_conv_normal;
		pwr_o.converting |-> pwr_o.mode == PM_NORMAL;
	endproperty
	a_conv_normal: assert property (p_conv_normal)
		else $error("low power during conversion");
endmodule

bind apc_power_ctrl apc_power_ctrl_checker chk_u (
	.clock_i         (clock_i),
	.rst_n_i         (rst_n_i),
	.hw_shutdown_n_i (hw_shutdown_n_i),
	.pwr_o           (pwr_o)
);

// ===== bench/test_apc_power_ctrl.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module test_apc_power_ctrl;
	import apc_pkg::*;
	typedef struct {
		logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;
	} apc_row_t;
	apc_row_t rows [8] = '{
		'{1'b0, REG_CTRL, 32'h0, CTRL_RESET, 1'b0}, '{1'b1, REG_CTRL, 32'h5, 32'h0, 1'b0},
		'{1'b0, REG_CTRL, 32'h0, 32'h5, 1'b0}, '{1'b0, REG_COUNT, 32'h0, 32'h0, 1'b0},
		'{1'b1, REG_COUNT, 32'h1234, 32'h0, 1'b0}, '{1'b0, REG_COUNT, 32'h0, 32'h0, 1'b0},
		'{1'b1, 12'h00C, 32'h7, 32'h0, 1'b1}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1}};
	logic clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic        pready_o, pslverr_o, sclk, cs_n, din, hw_shutdown_n_i = 1'b1, err;
	apc_pwr_t    pwr_o;
	int          failures = 0, cmp_count = 0, cyc = 0;

	apc_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
	apc_power_ctrl dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_i(sclk), .cs_n_i(cs_n),
		.din_i(din), .hw_shutdown_n_i(hw_shutdown_n_i), .pwr_o(pwr_o));

	// ------------------------------------------------------------
	// clock, timeout, helpers
	// ------------------------------------------------------------
	initial forever #5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		tick(20);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk("prdata", rows[i].r, rd);
			chk("pslverr", 32'(rows[i].e), 32'(err));
		end
		$display("test registers done");
		for (int m = 0; m < 4; m++) begin
			fork
				host_u.frame(8'h80 | 8'(m), m == 1 || m == 2);
			join_none
			tick(150);
			chk("awake mode", 32'(PM_NORMAL), 32'(pwr_o.mode));
			if (m >= 2)
				chk("ready", 32'h1, 32'(pwr_o.ready));
			wait fork;
			tick(20);
			chk("mode", 32'(m), 32'(pwr_o.mode));
			chk("comp_on", 32'(m != 0), 32'(pwr_o.comp_on));
			chk("ref_on", 32'(m != 0), 32'(pwr_o.ref_on));
			chk("comp_full", 32'(m == 3), 32'(pwr_o.comp_full));
			apb(1'b0, REG_STATUS, 32'h0);
			chk("field", 32'(m), 32'(rd[ST_FIELD_LSB+:2]));
			apb(1'b0, REG_COUNT, 32'h0);
			chk("count", 32'(m + 1), rd);
		end
		$display("test power modes done");
		fork
			host_u.frame(8'h83, 1'b0);
		join_none
		tick(150);
		chk("converting", 32'h1, 32'(pwr_o.converting));
		hw_shutdown_n_i <= 1'b0;
		tick(10);
		chk("hw_down", 32'h1, 32'(pwr_o.hw_down));
		chk("stopped", 32'h0, 32'(pwr_o.converting));
		wait fork;
		apb(1'b0, REG_STATUS, 32'h0);
		chk("abort", 32'h1, 32'(rd[ST_ABORT]));
		chk("field kept", 32'h3, 32'(rd[ST_FIELD_LSB+:2]));
		apb(1'b1, REG_STATUS, 32'h1 << ST_ABORT);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("abort clear", 32'h0, 32'(rd[ST_ABORT]));
		hw_shutdown_n_i <= 1'b1;
		tick(10);
		chk("release mode", 32'(PM_NORMAL), 32'(pwr_o.mode));
		tick(20);
		chk("ready", 32'h1, 32'(pwr_o.ready));
		apb(1'b0, REG_COUNT, 32'h0);
		chk("count", 32'h4, rd);
		$display("test shutdown done");
		host_u.frame(8'h80, 1'b0);
		tick(20);
		chk("deep mode", 32'(PM_DEEP), 32'(pwr_o.mode));
		rst_n_i <= 1'b0;
		tick(2);
		rst_n_i <= 1'b1;
		tick(2);
		chk("reset mode", 32'(PM_NORMAL), 32'(pwr_o.mode));
		tick(int'(READY_CYC) - 18);
		chk("reset ready", 32'h0, 32'(pwr_o.ready));
		tick(25);
		chk("reset ready", 32'h1, 32'(pwr_o.ready));
		apb(1'b0, REG_COUNT, 32'h0);
		chk("reset count", 32'(COUNT_RESET), rd);
		$display("test reset done");
		host_u.frame(8'h80, 1'b0);
		tick(20);
		fork
			host_u.frame(8'h83, 1'b0);
		join_none
		tick(150);
		chk("wake ready", 32'h0, 32'(pwr_o.ready));
		wait fork;
		tick(20);
		chk("settled", 32'h1, 32'(pwr_o.ready));
		apb(1'b0, REG_COUNT, 32'h0);
		chk("count", 32'h2, rd);
		$display("test deep wake done");
		test_done();
	end
endmodule
